// File: dtc_params.svh
// Register addresses, field positions, reset values and timing counts
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define DTC_ADDR_CTL   8'h88
`define DTC_ADDR_MODE  8'h89
`define DTC_ADDR_LO0   8'h8A
`define DTC_ADDR_LO1   8'h8B
`define DTC_ADDR_HI0   8'h8C
`define DTC_ADDR_HI1   8'h8D

// ----------------------------------------------------------------
// Control/flag register bit positions
// ----------------------------------------------------------------
`define DTC_CTL_OVF1   7
`define DTC_CTL_RUN1   6
`define DTC_CTL_OVF0   5
`define DTC_CTL_RUN0   4
`define DTC_CTL_EDG1   3
`define DTC_CTL_TRG1   2
`define DTC_CTL_EDG0   1
`define DTC_CTL_TRG0   0

// ----------------------------------------------------------------
// Mode register fields (unit 1 in upper nibble)
// ----------------------------------------------------------------
`define DTC_MOD_QUAL   3
`define DTC_MOD_SRC    2
`define DTC_MOD_MHI    1
`define DTC_MOD_MLO    0
`define DTC_MOD_U1OFS  4

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define DTC_CTL_RST    8'h00
`define DTC_MODE_RST   8'h00
`define DTC_CNT_RST    8'h00
`define DTC_MC_CLKS    3'h6

`endif

// File: dtc_pins.sv
// Far-side model of the count and gate pins
module dtc_pins (
  input wire logic sys_clk,
  output logic     count_pin_0,
  output logic     count_pin_1,
  output logic     ext_irq_pin_0,
  output logic     ext_irq_pin_1
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins rest high; the unit 1 count pin is never moved
  initial {count_pin_0, count_pin_1, ext_irq_pin_0, ext_irq_pin_1} = 4'hF;
  // Each level held hold clocks; six is the shortest legal
  task automatic pulse(input int n, input int hold);
    repeat (n) begin
      count_pin_0 = 1'b0;
      repeat (hold) @(negedge sys_clk);
      count_pin_0 = 1'b1;
      repeat (hold) @(negedge sys_clk);
    end
  endtask : pulse
  task automatic gate(input logic lvl);
    @(negedge sys_clk);
    ext_irq_pin_0 = lvl;
  endtask : gate
  task automatic gate1(input logic lvl);
    @(negedge sys_clk);
    ext_irq_pin_1 = lvl;
  endtask : gate1
endmodule : dtc_pins

// File: dtc_pkg.sv
// Types shared by the dual timer/counter unit
package dtc_pkg;

  // Operating modes in the order of their two-bit codes
  typedef enum logic [1:0] {
    DTC_M13,
    DTC_M16,
    DTC_M8AR,
    DTC_MSPLIT
  } dtc_mode_e;

  typedef logic [7:0] dtc_byte_t;

endpackage : dtc_pkg

// File: dtc_props.sv
// Port checker for the dual timer unit
`include "dtc_params.svh"
module dtc_props (
  input wire logic               sys_clk,
  input wire logic               sys_rst,
  input wire logic [7:0]         sfr_addr,
  input wire logic               sfr_wr,
  input wire logic               sfr_rd,
  input wire dtc_pkg::dtc_byte_t sfr_wdata,
  input wire logic [7:0]         sfr_rdata,
  input wire logic               ext_irq_pin_0,
  input wire logic               ack_ovf_0,
  input wire logic               ack_ext_0,
  input wire logic               ovf_flag_0,
  input wire logic               ovf_flag_1,
  input wire logic               ext_edge_flag_0,
  input wire logic               baud_ovf_pulse
);
  import dtc_pkg::*;
  // ----
  // Mirrors
  // ----
  logic [2:0] mc_q, mc_d;
  logic       trg_q, trg_d;
  dtc_byte_t  mod_q, mod_d;
  // Divider restarts with reset, so the tick phase is known here
  always_comb begin
    mc_d  = (mc_q == 3'h5) ? 3'h0 : mc_q + 3'h1;
    trg_d = (sfr_wr && sfr_addr == `DTC_ADDR_CTL) ? sfr_wdata[0] : trg_q;
    mod_d = (sfr_wr && sfr_addr == `DTC_ADDR_MODE) ? sfr_wdata : mod_q;
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) {mc_q, trg_q, mod_q} <= 12'h000;
    else {mc_q, trg_q, mod_q} <= {mc_d, trg_d, mod_d};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  mode_rdback_a: assert property (
    sfr_rd && sfr_addr == `DTC_ADDR_MODE |=> sfr_rdata == $past(mod_q))
    else $error("mode readback wrong");
  ovf0_tick_a: assert property (
    $rose(ovf_flag_0) && !$past(sfr_wr) |-> $past(mc_q) == 3'h5)
    else $error("unit 0 flag off tick");
  ovf1_tick_a: assert property (
    $rose(ovf_flag_1) && !$past(sfr_wr) |-> $past(mc_q) == 3'h5)
    else $error("unit 1 flag off tick");
  baud_pulse_a: assert property (
    baud_ovf_pulse |-> $past(mc_q) == 3'h5 ##1 !baud_ovf_pulse)
    else $error("baud pulse bad");
  // A count overflow only lands on a tick and beats the acknowledge
  ovf_ack_a: assert property (
    ack_ovf_0 && mc_q != 3'h5 |=> !ovf_flag_0)
    else $error("ack kept flag");
  edge_set_a: assert property (
    trg_q && $fell(ext_irq_pin_0) |-> ##[1:2] ext_edge_flag_0)
    else $error("edge missed");
  level_mirror_a: assert property (
    !trg_q && !$past(sfr_wr) |-> ext_edge_flag_0 == !$past(ext_irq_pin_0))
    else $error("level flag wrong");
  edge_ack_a: assert property (
    trg_q && ack_ext_0 && ext_irq_pin_0 |=> !ext_edge_flag_0)
    else $error("edge ack ignored");
endmodule : dtc_props
bind dtc_top dtc_props u_props (.*);

// File: dtc_top.sv
// Dual 16-bit timer/counter with shared mode and control/flag registers
//
// Contract
// RULE1: qualify bit gates counting by interrupt pin high
// RULE2: source bit picks machine cycles or count pin
// RULE3: two-bit field selects one of four modes
// RULE4: mode zero counts thirteen bits, prescaler five
// RULE5: wrap from all ones sets overflow flag
// RULE6: count passes when run and qualify allow
// RULE7: starting a unit never clears its count
// RULE8: mode one uses all sixteen bits
// RULE9: mode two reloads low byte from high
// RULE10: unit one in mode three stops
// RULE11: split mode: high byte uses unit one controls
// RULE12: unit one keeps supplying overflows during split
// RULE13: overflow flag cleared by acknowledge or software
// RULE14: software alone sets and clears run bits
// RULE15: edge flag set on edge, cleared likewise
// RULE16: trigger bit picks falling edge or level
// RULE17: timer counts once per six clocks
// RULE18: count pin falling edge counts next cycle
// RULE19: count source holds each level one cycle
// RULE20: acknowledge inputs clear flags same cycle

`include "dtc_params.svh"

module dtc_top (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire dtc_pkg::dtc_byte_t sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  input  wire logic              count_pin_0,
  input  wire logic              count_pin_1,
  input  wire logic              ext_irq_pin_0,
  input  wire logic              ext_irq_pin_1,
  input  wire logic              ack_ovf_0,
  input  wire logic              ack_ovf_1,
  input  wire logic              ack_ext_0,
  input  wire logic              ack_ext_1,
  output logic                   ovf_flag_0,
  output logic                   ovf_flag_1,
  output logic                   ext_edge_flag_0,
  output logic                   ext_edge_flag_1,
  output logic                   baud_ovf_pulse
);
  import dtc_pkg::*;

  // ----------------------------------------------------------------
  // Step function for one unit
  // ----------------------------------------------------------------
  // Returns {overflow, next high byte, next low byte}
  function automatic logic [16:0] dtc_step(
    input dtc_mode_e m,
    input logic [7:0] th,
    input logic [7:0] tl
  );
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    s13 = {1'b0, th, tl[4:0]} + 14'h0001;
    s16 = {1'b0, th, tl} + 17'h00001;
    s8  = {1'b0, tl} + 9'h001;
    case (m)
      DTC_M13: begin
        // Upper low-byte bits are left alone, not part of the count
        dtc_step = {s13[13], s13[12:5], tl[7:5], s13[4:0]}; // RULE4
      end
      DTC_M16: begin
        dtc_step = s16; // RULE8
      end
      DTC_M8AR: begin
        dtc_step = {s8[8], th, s8[8] ? th : s8[7:0]}; // RULE9
      end
      DTC_MSPLIT: begin
        dtc_step = {s8[8], th, s8[7:0]};
      end
      default: begin
        dtc_step = {1'b0, th, tl};
      end
    endcase
  endfunction : dtc_step

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0] div_q, div_d;
  logic       tick;
  logic [1:0] smp_q, smp_d;
  logic [1:0] smp_prev_q, smp_prev_d;
  logic [1:0] irq_prev_q, irq_prev_d;
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] mode_q, mode_d;
  logic [7:0] lo0_q, lo0_d, hi0_q, hi0_d;
  logic [7:0] lo1_q, lo1_d, hi1_q, hi1_d;
  logic [7:0] rdata_q, rdata_d;
  logic       bovf_q, bovf_d;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic [1:0] pin_cnt, pin_irq;
  logic [1:0] run, qual, src, en, falln, inc;
  dtc_mode_e  m0, m1;
  logic [16:0] st0, st1;
  logic [8:0]  hs;

  assign pin_cnt = {count_pin_1, count_pin_0};
  assign pin_irq = {ext_irq_pin_1, ext_irq_pin_0};
  assign run     = {ctl_q[`DTC_CTL_RUN1], ctl_q[`DTC_CTL_RUN0]}; // RULE14
  assign m0      = dtc_mode_e'(mode_q[`DTC_MOD_MHI:`DTC_MOD_MLO]); // RULE3
  assign m1      = dtc_mode_e'(mode_q[`DTC_MOD_MHI + `DTC_MOD_U1OFS:
                                      `DTC_MOD_MLO + `DTC_MOD_U1OFS]);
  assign tick    = (div_q == `DTC_MC_CLKS - 3'h1); // RULE17

  // Per-unit gating and input selection
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_unit
      assign qual[gi]  = mode_q[`DTC_MOD_QUAL + 4 * gi];
      assign src[gi]   = mode_q[`DTC_MOD_SRC + 4 * gi];
      // Qualified units run only while the interrupt pin is high
      assign en[gi]    = run[gi] & (~qual[gi] | pin_irq[gi]); // RULE1 RULE6
      // Pin count uses samples from the two previous machine cycles
      assign falln[gi] = smp_prev_q[gi] & ~smp_q[gi]; // RULE18
      assign inc[gi]   = en[gi] & tick & (src[gi] ? falln[gi] : 1'b1); // RULE2
    end
  endgenerate

  assign st0 = dtc_step(m0, hi0_q, lo0_q);
  assign st1 = dtc_step(m1, hi1_q, lo1_q);
  // Split-mode high byte counts machine cycles under unit one's run bit
  assign hs  = {1'b0, hi0_q} + 9'h001;

  // ----------------------------------------------------------------
  // Machine-cycle divider and pin samplers: next state
  // ----------------------------------------------------------------
  // Pins are sampled once per machine cycle, so a level shorter than
  // six clocks may be missed entirely by the counter
  always_comb begin
    div_d      = tick ? 3'h0 : div_q + 3'h1;
    smp_d      = tick ? pin_cnt : smp_q;
    smp_prev_d = tick ? smp_q : smp_prev_q;
    irq_prev_d = pin_irq;
  end

  // Divider and samplers: registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q      <= 3'h0;
      smp_q      <= 2'h0;
      smp_prev_q <= 2'h0;
      irq_prev_q <= 2'h3;
    end else begin
      div_q      <= div_d;
      smp_q      <= smp_d;
      smp_prev_q <= smp_prev_d;
      irq_prev_q <= irq_prev_d;
    end
  end

  // ----------------------------------------------------------------
  // Counters, flags and register port: next state
  // ----------------------------------------------------------------
  // Order of precedence: counting, then software write, then
  // acknowledge clears, then hardware sets, so an event landing on
  // the clearing cycle is kept
  always_comb begin
    logic       wr_ctl;
    logic       set0, set1, bset;
    logic [1:0] edg;
    wr_ctl  = sfr_wr & (sfr_addr == `DTC_ADDR_CTL);
    set0    = 1'b0;
    set1    = 1'b0;
    bset    = 1'b0;
    edg     = irq_prev_q & ~pin_irq;
    ctl_d   = ctl_q;
    mode_d  = mode_q;
    lo0_d   = lo0_q;
    hi0_d   = hi0_q;
    lo1_d   = lo1_q;
    hi1_d   = hi1_q;
    rdata_d = rdata_q;

    // Unit 0 counting; split mode leaves its high byte to unit one
    if (inc[0]) begin
      lo0_d = st0[7:0];
      if (m0 != DTC_MSPLIT) begin
        hi0_d = st0[15:8];
      end
      set0 = st0[16]; // RULE5
    end
    if ((m0 == DTC_MSPLIT) && run[1] && tick) begin
      hi0_d = hs[7:0]; // RULE11
      set1  = hs[8]; // RULE11
    end

    // Unit 1 halts in its own split code, but its run bit still clocks the split high byte
    if (inc[1] && (m1 != DTC_MSPLIT)) begin // RULE10 RULE12
      lo1_d = st1[7:0];
      hi1_d = st1[15:8];
      bset  = st1[16];
      // Its flag belongs to the split high byte while unit 0 is split
      if (m0 != DTC_MSPLIT) begin
        set1 = st1[16]; // RULE5
      end
    end

    // Software writes; run bits change only here
    if (sfr_wr) begin
      case (sfr_addr)
        `DTC_ADDR_CTL:  ctl_d  = sfr_wdata; // RULE14 RULE7
        `DTC_ADDR_MODE: mode_d = sfr_wdata;
        `DTC_ADDR_LO0:  lo0_d  = sfr_wdata;
        `DTC_ADDR_HI0:  hi0_d  = sfr_wdata;
        `DTC_ADDR_LO1:  lo1_d  = sfr_wdata;
        `DTC_ADDR_HI1:  hi1_d  = sfr_wdata;
        default: begin
        end
      endcase
    end

    // Acknowledge clears the overflow flags in the same cycle
    if (ack_ovf_0) begin
      ctl_d[`DTC_CTL_OVF0] = 1'b0; // RULE13 RULE20
    end
    if (ack_ovf_1) begin
      ctl_d[`DTC_CTL_OVF1] = 1'b0; // RULE13 RULE20
    end
    if (set0) begin
      ctl_d[`DTC_CTL_OVF0] = 1'b1; // RULE13
    end
    if (set1) begin
      ctl_d[`DTC_CTL_OVF1] = 1'b1; // RULE13
    end

    // Edge mode latches a falling edge; level mode tracks a low pin
    if (ctl_q[`DTC_CTL_TRG0]) begin
      if (ack_ext_0) begin
        ctl_d[`DTC_CTL_EDG0] = 1'b0; // RULE15 RULE20
      end
      if (edg[0]) begin
        ctl_d[`DTC_CTL_EDG0] = 1'b1; // RULE15 RULE16
      end
    end else if (!wr_ctl) begin
      ctl_d[`DTC_CTL_EDG0] = ~pin_irq[0]; // RULE16
    end
    if (ctl_q[`DTC_CTL_TRG1]) begin
      if (ack_ext_1) begin
        ctl_d[`DTC_CTL_EDG1] = 1'b0; // RULE15 RULE20
      end
      if (edg[1]) begin
        ctl_d[`DTC_CTL_EDG1] = 1'b1; // RULE15 RULE16
      end
    end else if (!wr_ctl) begin
      ctl_d[`DTC_CTL_EDG1] = ~pin_irq[1]; // RULE16
    end

    // Read data is captured at the edge ending the read strobe cycle and shows one cycle later
    if (sfr_rd) begin
      case (sfr_addr)
        `DTC_ADDR_CTL:  rdata_d = ctl_q;
        `DTC_ADDR_MODE: rdata_d = mode_q;
        `DTC_ADDR_LO0:  rdata_d = lo0_q;
        `DTC_ADDR_HI0:  rdata_d = hi0_q;
        `DTC_ADDR_LO1:  rdata_d = lo1_q;
        `DTC_ADDR_HI1:  rdata_d = hi1_q;
        default:        rdata_d = 8'h00;
      endcase
    end
    bovf_d = bset; // RULE12
  end

  // Counters, flags and register port: registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q   <= `DTC_CTL_RST;
      mode_q  <= `DTC_MODE_RST;
      lo0_q   <= `DTC_CNT_RST;
      hi0_q   <= `DTC_CNT_RST;
      lo1_q   <= `DTC_CNT_RST;
      hi1_q   <= `DTC_CNT_RST;
      rdata_q <= 8'h00;
      bovf_q  <= 1'b0;
    end else begin
      ctl_q   <= ctl_d;
      mode_q  <= mode_d;
      lo0_q   <= lo0_d;
      hi0_q   <= hi0_d;
      lo1_q   <= lo1_d;
      hi1_q   <= hi1_d;
      rdata_q <= rdata_d;
      bovf_q  <= bovf_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sfr_rdata       = rdata_q;
  assign ovf_flag_0      = ctl_q[`DTC_CTL_OVF0];
  assign ovf_flag_1      = ctl_q[`DTC_CTL_OVF1];
  assign ext_edge_flag_0 = ctl_q[`DTC_CTL_EDG0];
  assign ext_edge_flag_1 = ctl_q[`DTC_CTL_EDG1];
  assign baud_ovf_pulse  = bovf_q;

endmodule : dtc_top

// File: test_dual_timer_counter_unit.sv
// Self-checking bench for the dual timer/counter unit
`include "dtc_params.svh"
module test_dual_timer_counter_unit;
  timeunit 1ns;
  timeprecision 1ns;
  import dtc_pkg::*;
  logic       sys_clk = 1'b0, sys_rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_rdata, v;
  dtc_byte_t  sfr_wdata = 8'h00;
  logic       ack_ovf_0 = 1'b0, ack_ovf_1 = 1'b0;
  logic       ack_ext_0 = 1'b0, ack_ext_1 = 1'b0;
  logic       count_pin_0, count_pin_1, ext_irq_pin_0, ext_irq_pin_1;
  logic       ovf_flag_0, ovf_flag_1, ext_edge_flag_0, ext_edge_flag_1;
  logic       baud_ovf_pulse;
  int         n_mismatch = 0, checks_done = 0, cyc = 0;
  wire  [2:0] flags = {baud_ovf_pulse, ovf_flag_1, ovf_flag_0};
  dtc_top  DUT (.*);
  dtc_pins pins (.*);
  always #5 sys_clk = ~sys_clk;
  // Hang guard: the run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ----
  // Bus and check tasks
  // ----
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, d);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge sys_clk);
    sfr_wr = 1'b0;
  endtask : wr
  // Read data is registered, so it is taken one edge later
  task automatic rdchk(input string nm, input logic [7:0] a, exp);
    @(negedge sys_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge sys_clk);
    sfr_rd = 1'b0;
    v = sfr_rdata;
    chk(nm, v, exp);
  endtask : rdchk
  task automatic wflag(input int i);
    repeat (40) if (flags[i] !== 1'b1) @(negedge sys_clk);
    chk("flag", 8'(flags[i]), 8'h01);
  endtask : wflag
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial begin
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    rdchk("ctl", `DTC_ADDR_CTL, `DTC_CTL_RST);
    rdchk("hole", 8'h90, 8'h00);
    wr(`DTC_ADDR_MODE, 8'h5A);
    rdchk("mode", `DTC_ADDR_MODE, 8'h5A);
    $display("map done");
    wr(`DTC_ADDR_MODE, 8'h09);
    wr(`DTC_ADDR_LO0, 8'h40);
    pins.gate(1'b0);
    wr(`DTC_ADDR_CTL, 8'h10);
    repeat (30) @(negedge sys_clk);
    rdchk("gated", `DTC_ADDR_LO0, 8'h40);
    pins.gate(1'b1);
    repeat (12) @(negedge sys_clk);
    rdchk("ungated", `DTC_ADDR_LO0, 8'h42);
    $display("gate done");
    wr(`DTC_ADDR_MODE, 8'h01);
    wr(`DTC_ADDR_LO0, 8'hFE);
    wr(`DTC_ADDR_HI0, 8'hFF);
    wflag(0);
    rdchk("hi0 m1", `DTC_ADDR_HI0, 8'h00);
    ack_ovf_0 = 1'b1;
    @(negedge sys_clk);
    ack_ovf_0 = 1'b0;
    chk("ack", 8'(ovf_flag_0), 8'h00);
    $display("mode 1 done");
    wr(`DTC_ADDR_MODE, 8'h00);
    wr(`DTC_ADDR_HI0, 8'hFF);
    wr(`DTC_ADDR_LO0, 8'h1F);
    wflag(0);
    rdchk("hi0 m0", `DTC_ADDR_HI0, 8'h00);
    wr(`DTC_ADDR_CTL, 8'h10);
    chk("sw clear", 8'(ovf_flag_0), 8'h00);
    $display("mode 0 done");
    wr(`DTC_ADDR_MODE, 8'h02);
    wr(`DTC_ADDR_HI0, 8'h80);
    wr(`DTC_ADDR_LO0, 8'hFF);
    wflag(0);
    rdchk("reload", `DTC_ADDR_LO0, 8'h80);
    rdchk("hi0 kept", `DTC_ADDR_HI0, 8'h80);
    $display("mode 2 done");
    wr(`DTC_ADDR_MODE, 8'h05);
    wr(`DTC_ADDR_LO0, 8'h00);
    pins.pulse(3, 12);
    pins.pulse(2, 6);
    repeat (12) @(negedge sys_clk);
    rdchk("events", `DTC_ADDR_LO0, 8'h05);
    $display("event done");
    wr(`DTC_ADDR_MODE, 8'h33);
    wr(`DTC_ADDR_CTL, 8'h40);
    wr(`DTC_ADDR_LO1, 8'hFE);
    wr(`DTC_ADDR_HI0, 8'hFF);
    wflag(1);
    ack_ovf_1 = 1'b1;
    @(negedge sys_clk);
    ack_ovf_1 = 1'b0;
    chk("ack 1", 8'(ovf_flag_1), 8'h00);
    rdchk("lo1 held", `DTC_ADDR_LO1, 8'hFE);
    wr(`DTC_ADDR_HI1, 8'hFE);
    wr(`DTC_ADDR_MODE, 8'h23);
    wflag(2);
    chk("baud", 8'(baud_ovf_pulse), 8'h01);
    chk("no flag 1", 8'(ovf_flag_1), 8'h00);
    $display("split done");
    wr(`DTC_ADDR_CTL, 8'h05);
    pins.gate(1'b0);
    repeat (2) @(negedge sys_clk);
    chk("edge", 8'(ext_edge_flag_0), 8'h01);
    pins.gate(1'b1);
    ack_ext_0 = 1'b1;
    @(negedge sys_clk);
    ack_ext_0 = 1'b0;
    chk("edge ack", 8'(ext_edge_flag_0), 8'h00);
    pins.gate1(1'b0);
    repeat (2) @(negedge sys_clk);
    chk("edge 1", 8'(ext_edge_flag_1), 8'h01);
    pins.gate1(1'b1);
    ack_ext_1 = 1'b1;
    @(negedge sys_clk);
    ack_ext_1 = 1'b0;
    chk("edge 1 ack", 8'(ext_edge_flag_1), 8'h00);
    wr(`DTC_ADDR_CTL, 8'h00);
    pins.gate(1'b0);
    repeat (2) @(negedge sys_clk);
    chk("level", 8'(ext_edge_flag_0), 8'h01);
    chk("level 1", 8'(ext_edge_flag_1), 8'h00);
    $display("flag done");
    conclude();
  end
endmodule : test_dual_timer_counter_unit
